// >>> core/eqc_fifo.sv
// synchronous fifo with valid and ready on both sides
module eqc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  wire logic push;
  wire logic pop;

  assign o_in_ready = count_reg != FULL_CNT;
  assign o_out_valid = count_reg != '0;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem_reg[rd_ptr_reg];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : eqc_fifo

// >>> core/eqc_five_band_eq_control.sv
// five-band equaliser control: registers, gain decode, clock budget check, sample buffer
// Behaviour
// R1: band gain code 00000 is -12 dB, rising 1 dB per step to 11000, +12 dB.
// R2: software never writes gain codes 11001 to 11111; they are reserved.
// R3: all band gain fields reset to 0x0C, unity gain.
// R4: each equaliser holds a block of 16-bit coefficient words loaded by software.
// R5: an enable request is refused when the system clock lacks cycles for it.
// R6: a refused request leaves every already running path untouched.
// R7: effects status reports which equaliser, dynamic range and low/high pass paths really run.
// R8: mixer status bits report which mixers were really enabled.
// R9: bit 0 of the second gain register picks shelving (0) or peak (1); resets 0.
// R10: bit 0 of the first gain register requests the equaliser on; resets off.
//
// Decided for this implementation: strobed register access.
module eqc_five_band_eq_control
  import eqc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic [CYC_W-1:0] i_system_clock_budget,
  input wire logic [CYC_W-1:0] i_system_clock_in_use,
  input wire logic [FX_W-1:0] i_other_fx_active,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [SAMPLE_W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [SAMPLE_W-1:0] o_out_data,
  output logic o_out_eq_applied,
  output logic o_equaliser_enable,
  output logic o_band_one_filter_type,
  output logic signed [DB_W-1:0] o_band_one_gain_db,
  output logic signed [DB_W-1:0] o_band_two_gain_db,
  output logic signed [DB_W-1:0] o_band_three_gain_db,
  output logic signed [DB_W-1:0] o_band_four_gain_db,
  output logic signed [DB_W-1:0] o_band_five_gain_db,
  output logic o_gain_reserved,
  output logic [N_MIX-1:0] o_mixer_active,
  output logic [FX_W-1:0] o_effects_path_status
);
  localparam int SUM_W = CYC_W + 2;
  localparam int NB = 5;

  // gain and mode fields
  logic [GAIN_W-1:0] gain_reg [NB];
  logic band_one_filter_type_reg;
  logic equaliser_enable_reg;
  logic equaliser_enable_next;
  logic [DATA_W-1:0] eq3_coef_reg [COEF_WORDS];
  logic [DATA_W-1:0] eq4_coef_reg [COEF_WORDS];
  logic [N_MIX-1:0] mixer_active_reg;
  logic [N_MIX-1:0] mixer_active_next;
  logic mixer_reject;
  logic uc_eq_reg;
  logic uc_mix_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic signed [DB_W-1:0] gain_db_reg [NB];
  logic gain_reserved_reg;

  // bus decode
  wire logic wr_gain_low;
  wire logic wr_gain_high;
  wire logic wr_mix;
  wire logic wr_uc;
  wire logic [ADDR_W-1:0] eq3_off;
  wire logic [ADDR_W-1:0] eq4_off;
  wire logic hit_eq3_coef;
  wire logic hit_eq4_coef;
  wire logic [COEF_IDX_W-1:0] eq3_idx;
  wire logic [COEF_IDX_W-1:0] eq4_idx;
  wire logic [GAIN_W-1:0] wr_field_hi;
  wire logic [GAIN_W-1:0] wr_field_mid;
  wire logic [GAIN_W-1:0] wr_field_lo;
  wire logic wr_enable_bit;
  wire logic wr_mode_bit;
  wire logic [N_MIX-1:0] mix_kept;
  wire logic [N_MIX-1:0] mix_fresh;

  assign wr_gain_low = i_wr && (i_addr == EQ4_GAIN_LOW_ADDR);
  assign wr_gain_high = i_wr && (i_addr == EQ4_GAIN_HIGH_ADDR);
  assign wr_mix = i_wr && (i_addr == MIX_ENABLE_ADDR);
  assign wr_uc = i_wr && (i_addr == UNDERCLOCK_ADDR);
  assign eq3_off = i_addr - EQ3_COEF_BASE;
  assign eq4_off = i_addr - EQ4_COEF_BASE;
  assign hit_eq3_coef = (i_addr >= EQ3_COEF_BASE) && (eq3_off <= COEF_LAST);
  assign hit_eq4_coef = (i_addr >= EQ4_COEF_BASE) && (eq4_off <= COEF_LAST);
  assign eq3_idx = eq3_off[COEF_IDX_W-1:0];
  assign eq4_idx = eq4_off[COEF_IDX_W-1:0];

  // write data fields
  assign wr_field_hi = i_wdata[GAIN_HI_LSB +: GAIN_W];
  assign wr_field_mid = i_wdata[GAIN_MID_LSB +: GAIN_W];
  assign wr_field_lo = i_wdata[GAIN_LO_LSB +: GAIN_W];
  assign wr_enable_bit = i_wdata[ENABLE_BIT];
  assign wr_mode_bit = i_wdata[MODE_BIT];
  // mixers already running that stay, and bits asked for afresh
  assign mix_kept = mixer_active_reg & i_wdata[N_MIX-1:0];
  assign mix_fresh = i_wdata[N_MIX-1:0] & ~mixer_active_reg;

  // cycle load already committed outside and inside this block
  wire logic [SUM_W-1:0] outside_load;
  wire logic [SUM_W-1:0] eq_load;
  wire logic [SUM_W-1:0] budget;
  logic [SUM_W-1:0] mix_load;
  wire logic eq_request;
  wire logic eq_fits;
  wire logic eq_reject;

  assign outside_load = SUM_W'(i_system_clock_in_use);
  assign eq_load = equaliser_enable_reg ? SUM_W'(EQ_COST) : '0;
  assign budget = SUM_W'(i_system_clock_budget);

  always_comb begin
    mix_load = '0;
    for (int i = 0; i < N_MIX; i++) begin
      if (mixer_active_reg[i]) begin
        mix_load = mix_load + SUM_W'(MIX_COST);
      end
    end
  end

  wire logic [SUM_W-1:0] eq_need;
  wire logic eq_fresh;

  assign eq_request = wr_enable_bit;
  assign eq_need = outside_load + mix_load + SUM_W'(EQ_COST);
  assign eq_fits = eq_need <= budget; // see R5
  // only a fresh request can be refused; a running path stays on
  assign eq_fresh = wr_gain_low && eq_request && !equaliser_enable_reg;
  assign eq_reject = eq_fresh && !eq_fits; // see R6

  always_comb begin
    equaliser_enable_next = equaliser_enable_reg;
    if (wr_gain_low) begin
      if (!eq_request) begin
        equaliser_enable_next = 1'b0; // see R10
      end else if (!equaliser_enable_reg) begin
        equaliser_enable_next = eq_fits; // see R5
      end
    end
  end

  // mixers: kept bits stay, new ones are granted in bit order while cycles remain
  logic [SUM_W-1:0] mix_acc;
  always_comb begin
    mix_acc = '0;
    mixer_active_next = mixer_active_reg;
    mixer_reject = 1'b0;
    if (wr_mix) begin
      mix_acc = outside_load + eq_load;
      mixer_active_next = mix_kept;
      for (int i = 0; i < N_MIX; i++) begin
        if (mixer_active_next[i]) begin
          mix_acc = mix_acc + SUM_W'(MIX_COST);
        end
      end
      for (int i = 0; i < N_MIX; i++) begin
        if (mix_fresh[i]) begin
          if ((mix_acc + SUM_W'(MIX_COST)) <= budget) begin
            mixer_active_next[i] = 1'b1; // see R5
            mix_acc = mix_acc + SUM_W'(MIX_COST);
          end else begin
            mixer_reject = 1'b1; // see R6
          end
        end
      end
    end
  end

  // gain decoders
  logic signed [DB_W-1:0] gain_db [NB];
  logic [NB-1:0] band_reserved;
  wire logic any_reserved;
  assign any_reserved = |band_reserved;
  for (genvar b = 0; b < NB; b++) begin : g_band
    eqc_gain_decode u_dec (
      .i_code(gain_reg[b]),
      .o_gain_db(gain_db[b]), // see R1
      .o_reserved(band_reserved[b]) // see R2
    );
  end

  // field registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int b = 0; b < NB; b++) begin
        gain_reg[b] <= GAIN_RESET; // see R3
      end
      band_one_filter_type_reg <= 1'b0; // see R9
      equaliser_enable_reg <= 1'b0; // see R10
      mixer_active_reg <= '0;
    end else begin
      if (wr_gain_low) begin
        gain_reg[0] <= wr_field_hi;
        gain_reg[1] <= wr_field_mid;
        gain_reg[2] <= wr_field_lo;
      end
      if (wr_gain_high) begin
        gain_reg[3] <= wr_field_hi;
        gain_reg[4] <= wr_field_mid;
        band_one_filter_type_reg <= wr_mode_bit; // see R9
      end
      equaliser_enable_reg <= equaliser_enable_next;
      mixer_active_reg <= mixer_active_next; // see R8
    end
  end

  // coefficient blocks
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < COEF_WORDS; i++) begin
        eq3_coef_reg[i] <= COEF_RESET;
        eq4_coef_reg[i] <= COEF_RESET;
      end
    end else if (i_wr) begin
      if (hit_eq3_coef) begin
        eq3_coef_reg[eq3_idx] <= i_wdata; // see R4
      end
      if (hit_eq4_coef) begin
        eq4_coef_reg[eq4_idx] <= i_wdata; // see R4
      end
    end
  end

  // sticky refusal flags, write 1 clears, a new refusal wins
  wire logic uc_eq_clear;
  wire logic uc_mix_clear;

  assign uc_eq_clear = wr_uc && i_wdata[UC_EQ_BIT];
  assign uc_mix_clear = wr_uc && i_wdata[UC_MIX_BIT];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      uc_eq_reg <= 1'b0;
      uc_mix_reg <= 1'b0;
    end else begin
      uc_eq_reg <= eq_reject || (uc_eq_reg && !uc_eq_clear);
      uc_mix_reg <= mixer_reject || (uc_mix_reg && !uc_mix_clear);
    end
  end

  // effects status view
  wire logic [FX_W-1:0] fx_status;
  assign fx_status = (i_other_fx_active & ~(FX_W'(1) << FX_EQ4_BIT))
                   | (FX_W'(equaliser_enable_reg) << FX_EQ4_BIT); // see R7

  // read mux
  wire logic [DATA_W-1:0] rd_gain_low;
  wire logic [DATA_W-1:0] rd_gain_high;
  wire logic [DATA_W-1:0] rd_uc;
  wire logic [DATA_W-1:0] rdata_next;

  assign rd_gain_low = (DATA_W'(gain_reg[0]) << GAIN_HI_LSB)
                     | (DATA_W'(gain_reg[1]) << GAIN_MID_LSB)
                     | (DATA_W'(gain_reg[2]) << GAIN_LO_LSB)
                     | (DATA_W'(equaliser_enable_reg) << ENABLE_BIT);
  assign rd_gain_high = (DATA_W'(gain_reg[3]) << GAIN_HI_LSB)
                      | (DATA_W'(gain_reg[4]) << GAIN_MID_LSB)
                      | (DATA_W'(band_one_filter_type_reg) << MODE_BIT);
  assign rd_uc = (DATA_W'(uc_eq_reg) << UC_EQ_BIT)
               | (DATA_W'(uc_mix_reg) << UC_MIX_BIT)
               | (DATA_W'(any_reserved) << UC_RSV_BIT);

  // read address select
  wire logic sel_gain_low;
  wire logic sel_gain_high;
  wire logic sel_fx;
  wire logic sel_mix_enable;
  wire logic sel_mix_status;
  wire logic sel_uc;
  wire logic [DATA_W-1:0] rd_eq3_coef;
  wire logic [DATA_W-1:0] rd_eq4_coef;

  assign sel_gain_low = i_addr == EQ4_GAIN_LOW_ADDR;
  assign sel_gain_high = i_addr == EQ4_GAIN_HIGH_ADDR;
  assign sel_fx = i_addr == FX_STATUS_ADDR;
  assign sel_mix_enable = i_addr == MIX_ENABLE_ADDR;
  assign sel_mix_status = i_addr == MIX_STATUS_ADDR;
  assign sel_uc = i_addr == UNDERCLOCK_ADDR;
  assign rd_eq3_coef = eq3_coef_reg[eq3_idx];
  assign rd_eq4_coef = eq4_coef_reg[eq4_idx];

  assign rdata_next = sel_gain_low ? rd_gain_low :
                      sel_gain_high ? rd_gain_high :
                      sel_fx ? DATA_W'(fx_status) : // see R7
                      sel_mix_enable ? DATA_W'(mixer_active_reg) :
                      sel_mix_status ? DATA_W'(mixer_active_reg) : // see R8
                      sel_uc ? rd_uc :
                      hit_eq3_coef ? rd_eq3_coef :
                      hit_eq4_coef ? rd_eq4_coef :
                      '0;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= i_rd ? rdata_next : '0;
    end
  end

  // registered decoded gains for the filter datapath
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int b = 0; b < NB; b++) begin
        gain_db_reg[b] <= '0;
      end
      gain_reserved_reg <= 1'b0;
    end else begin
      for (int b = 0; b < NB; b++) begin
        gain_db_reg[b] <= gain_db[b];
      end
      gain_reserved_reg <= any_reserved;
    end
  end

  // sample buffer ahead of the filter datapath
  eqc_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(i_in_valid),
    .o_in_ready(o_in_ready),
    .i_in_data(i_in_data),
    .o_out_valid(o_out_valid),
    .i_out_ready(i_out_ready),
    .o_out_data(o_out_data)
  );

  assign o_out_eq_applied = equaliser_enable_reg;
  assign o_rdata = rdata_reg;
  assign o_equaliser_enable = equaliser_enable_reg;
  assign o_band_one_filter_type = band_one_filter_type_reg;
  assign o_band_one_gain_db = gain_db_reg[0];
  assign o_band_two_gain_db = gain_db_reg[1];
  assign o_band_three_gain_db = gain_db_reg[2];
  assign o_band_four_gain_db = gain_db_reg[3];
  assign o_band_five_gain_db = gain_db_reg[4];
  assign o_gain_reserved = gain_reserved_reg;
  assign o_mixer_active = mixer_active_reg;
  assign o_effects_path_status = fx_status;
endmodule : eqc_five_band_eq_control

// >>> core/eqc_gain_decode.sv
// decodes one 5-bit band gain code into signed dB
module eqc_gain_decode
  import eqc_pkg::*;
(
  input wire logic [GAIN_W-1:0] i_code,
  output logic signed [DB_W-1:0] o_gain_db,
  output logic o_reserved
);
  wire logic [DB_W-1:0] offset_db;

  assign o_reserved = i_code > GAIN_TOP;
  // linear 1 dB steps, code 0x0C is 0 dB
  assign offset_db = {1'b0, i_code} - {1'b0, GAIN_RESET};
  assign o_gain_db = o_reserved ? '0 : $signed(offset_db);
endmodule : eqc_gain_decode

// >>> core/eqc_pkg.sv
// constants, register map and field layout of the equaliser control block
package eqc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int SAMPLE_W = 24;
  localparam int FIFO_DEPTH = 8;
  localparam int GAIN_W = 5;
  localparam int DB_W = 6;
  localparam int COEF_WORDS = 19;
  localparam int COEF_IDX_W = 5;
  localparam int N_MIX = 8;
  localparam int CYC_W = 16;
  localparam int FX_W = 12;

  // register offsets, word addressed
  localparam logic [ADDR_W-1:0] MIX_ENABLE_ADDR = 12'h640;
  localparam logic [ADDR_W-1:0] MIX_STATUS_ADDR = 12'h641;
  localparam logic [ADDR_W-1:0] FX_STATUS_ADDR = 12'hE01;
  localparam logic [ADDR_W-1:0] UNDERCLOCK_ADDR = 12'hE02;
  localparam logic [ADDR_W-1:0] EQ3_COEF_BASE = 12'hE3E;
  localparam logic [ADDR_W-1:0] EQ4_GAIN_LOW_ADDR = 12'hE52;
  localparam logic [ADDR_W-1:0] EQ4_GAIN_HIGH_ADDR = 12'hE53;
  localparam logic [ADDR_W-1:0] EQ4_COEF_BASE = 12'hE54;
  localparam logic [ADDR_W-1:0] COEF_LAST = 12'h012;

  // field positions
  localparam int GAIN_HI_LSB = 11;
  localparam int GAIN_MID_LSB = 6;
  localparam int GAIN_LO_LSB = 1;
  localparam int ENABLE_BIT = 0;
  localparam int MODE_BIT = 0;
  localparam int FX_EQ4_BIT = 3;
  localparam int UC_EQ_BIT = 0;
  localparam int UC_MIX_BIT = 1;
  localparam int UC_RSV_BIT = 2;

  // reset values and gain coding
  localparam logic [GAIN_W-1:0] GAIN_RESET = 5'h0C;
  localparam logic [GAIN_W-1:0] GAIN_TOP = 5'h18;
  localparam logic [DATA_W-1:0] COEF_RESET = 16'h0000;

  // processing cost in system clock cycles per sample
  localparam logic [CYC_W-1:0] EQ_COST = 16'h0040;
  localparam logic [CYC_W-1:0] MIX_COST = 16'h0010;
endpackage : eqc_pkg

// >>> dv/eqc_five_band_eq_control_tb_top.sv
// self-checking bench of the equaliser control block
module eqc_five_band_eq_control_tb_top
  import eqc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_rst, i_wr, i_rd, i_in_valid, i_out_ready, o_in_ready, o_out_valid;
  logic stall, slow, rd_p1, eq_on, reserved, mode, applied;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, o_rdata, d;
  logic [CYC_W-1:0] budget, in_use;
  logic [FX_W-1:0] other, fx;
  logic [SAMPLE_W-1:0] i_in_data, o_out_data;
  logic signed [DB_W-1:0] db1, db2, db3, db4, db5;
  logic [N_MIX-1:0] mix;
  logic [31:0] rq[$], sq[$];
  logic [ADDR_W-1:0] ca[4] = '{EQ3_COEF_BASE, EQ3_COEF_BASE + COEF_LAST, EQ4_COEF_BASE,
    EQ4_COEF_BASE + COEF_LAST};
  int fail_count = 0, tests_run = 0, r;
  eqc_five_band_eq_control i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_system_clock_budget(budget), .i_system_clock_in_use(in_use), .i_other_fx_active(other),
    .i_in_valid(i_in_valid), .o_in_ready(o_in_ready), .i_in_data(i_in_data),
    .o_out_valid(o_out_valid), .i_out_ready(i_out_ready), .o_out_data(o_out_data),
    .o_out_eq_applied(applied), .o_equaliser_enable(eq_on), .o_band_one_filter_type(mode),
    .o_band_one_gain_db(db1), .o_band_two_gain_db(db2), .o_band_three_gain_db(db3),
    .o_band_four_gain_db(db4), .o_band_five_gain_db(db5), .o_gain_reserved(reserved),
    .o_mixer_active(mix), .o_effects_path_status(fx));
  eqc_sink i_sink (.i_clk(i_clk), .i_rst(i_rst), .i_stall(stall), .i_slow(slow),
    .o_ready(i_out_ready));
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    rq.push_back(e);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask : rd
  task automatic push(input logic [SAMPLE_W-1:0] v);
    int k;
    @(posedge i_clk);
    i_in_valid <= 1'b1;
    i_in_data <= v;
    for (k = 0; k < 300; k++) begin
      @(posedge i_clk);
      if (o_in_ready === 1'b1) break;
    end
    if (k == 300) begin
      $display("Error at %0t: input ready got %h expected %h", $time, 1'b0, 1'b1);
      fail_count++;
      conclude();
    end
    sq.push_back(v);
    i_in_valid <= 1'b0;
  endtask : push
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // read data and popped samples are matched against the oldest note
  always @(posedge i_clk) begin
    rd_p1 <= i_rd;
    if (rd_p1) chk(o_rdata, rq.pop_front());
    if (o_out_valid && i_out_ready) chk(o_out_data, sq.pop_front());
  end
  initial begin
    repeat (100000) @(posedge i_clk);
    fail_count++;
    conclude();
  end
  initial begin
    {i_addr, i_wdata, i_wr, i_rd, i_in_valid, i_in_data, slow, in_use} = '0;
    i_rst = 1'b1;
    stall = 1'b1;
    budget = 16'hFFFF;
    r = $urandom(55454);
    other = FX_W'($urandom);
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(EQ4_GAIN_LOW_ADDR, 16'h6318);
    rd(EQ4_GAIN_HIGH_ADDR, 16'h6300);
    rd(FX_STATUS_ADDR, {4'h0, other[11:4], 1'b0, other[2:0]});
    chk(fx, {other[11:4], 1'b0, other[2:0]});
    rd(12'h123, 16'h0000);
    chk({db1, db2, db3, db4, db5}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      d = DATA_W'($urandom);
      rd(ca[i], COEF_RESET);
      wr(ca[i], d);
      rd(ca[i], d);
    end
    wr(EQ4_GAIN_HIGH_ADDR, 16'h0001);
    chk(mode, 1'b1);
    rd(EQ4_GAIN_HIGH_ADDR, 16'h0001);
    for (int c = 0; c < 26; c++) begin
      wr(EQ4_GAIN_LOW_ADDR, {c[4:0], c[4:0], c[4:0], 1'b0});
      @(posedge i_clk);
      #1;
      chk({db1, db2, db3}, {3{c < 25 ? DB_W'(c - 12) : DB_W'(0)}});
      chk(reserved, c > 24);
    end
    wr(EQ4_GAIN_HIGH_ADDR, 16'hC000);
    @(posedge i_clk);
    #1;
    chk({db4, db5, mode}, {6'h0C, 6'h34, 1'b0});
    wr(EQ4_GAIN_LOW_ADDR, 16'h6318);
    @(posedge i_clk) budget <= 16'h003F;
    wr(EQ4_GAIN_LOW_ADDR, 16'h6319);
    chk(eq_on, 1'b0);
    rd(EQ4_GAIN_LOW_ADDR, 16'h6318);
    rd(UNDERCLOCK_ADDR, 16'h0001);
    wr(UNDERCLOCK_ADDR, 16'h0003);
    @(posedge i_clk) budget <= 16'h0050;
    wr(MIX_ENABLE_ADDR, 16'h0001);
    wr(EQ4_GAIN_LOW_ADDR, 16'h6319);
    chk({eq_on, applied}, 2'b11);
    wr(MIX_ENABLE_ADDR, 16'h0003);
    chk({eq_on, mix}, 9'h101);
    rd(MIX_STATUS_ADDR, 16'h0001);
    rd(MIX_ENABLE_ADDR, 16'h0001);
    rd(UNDERCLOCK_ADDR, 16'h0002);
    @(posedge i_clk) budget <= 16'h0000;
    wr(EQ4_GAIN_LOW_ADDR, 16'h6319);
    chk(eq_on, 1'b1);
    rd(FX_STATUS_ADDR, {4'h0, other[11:4], 1'b1, other[2:0]});
    chk(fx, {other[11:4], 1'b1, other[2:0]});
    wr(EQ4_GAIN_LOW_ADDR, 16'h6318);
    chk({eq_on, applied}, 2'b00);
    for (int i = 0; i < 8; i++) push(SAMPLE_W'($urandom));
    @(posedge i_clk);
    #1;
    chk(o_in_ready, 1'b0);
    @(posedge i_clk) stall <= 1'b0;
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) push(SAMPLE_W'($urandom));
    for (r = 0; r < 500 && sq.size() > 0; r++) @(posedge i_clk);
    #1;
    chk(o_out_valid, 1'b0);
    if (sq.size() != 0) begin
      $display("Error at %0t: samples left got %h expected %h", $time, sq.size(), 0);
      fail_count++;
    end
    conclude();
  end
endmodule : eqc_five_band_eq_control_tb_top

// >>> dv/eqc_monitor.sv
// port-level checker of the equaliser control block
module eqc_monitor
  import eqc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic [CYC_W-1:0] i_system_clock_budget,
  input wire logic [CYC_W-1:0] i_system_clock_in_use,
  input wire logic [FX_W-1:0] i_other_fx_active,
  input wire logic o_in_ready,
  input wire logic o_out_valid,
  input wire logic o_out_eq_applied,
  input wire logic o_equaliser_enable,
  input wire logic o_band_one_filter_type,
  input wire logic signed [DB_W-1:0] o_band_one_gain_db,
  input wire logic o_gain_reserved,
  input wire logic [N_MIX-1:0] o_mixer_active,
  input wire logic [FX_W-1:0] o_effects_path_status
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  int need;
  logic lo_wr;
  logic en_req;
  assign need = int'(i_system_clock_in_use) + $countones(o_mixer_active) * int'(MIX_COST)
    + int'(EQ_COST);
  assign lo_wr = i_wr && i_addr == EQ4_GAIN_LOW_ADDR;
  assign en_req = lo_wr && i_wdata[ENABLE_BIT];
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == '0)
    else $error("read data not idle");
  chk_enable_refuse: assert property (
    en_req && !o_equaliser_enable && need > int'(i_system_clock_budget) |=> !o_equaliser_enable)
    else $error("enable accepted without budget");
  chk_enable_grant: assert property (
    en_req && need <= int'(i_system_clock_budget) |=> o_equaliser_enable)
    else $error("enable not accepted");
  chk_running_kept: assert property (
    o_equaliser_enable && !(lo_wr && !i_wdata[ENABLE_BIT]) |=> o_equaliser_enable)
    else $error("running path dropped");
  chk_fx_status: assert property (o_effects_path_status ==
    {i_other_fx_active[FX_W-1:FX_EQ4_BIT+1], o_equaliser_enable, i_other_fx_active[2:0]})
    else $error("effects status wrong");
  chk_gain_decode: assert property (
    lo_wr && i_wdata[15:11] <= GAIN_TOP |-> ##2
    o_band_one_gain_db == $signed({1'b0, $past(i_wdata[15:11], 2)}) - 12)
    else $error("gain decode wrong");
  chk_reserved_flag: assert property (
    lo_wr && i_wdata[15:11] > GAIN_TOP |=> ##1 o_gain_reserved)
    else $error("reserved code not flagged");
  chk_mode_write: assert property (
    i_wr && i_addr == EQ4_GAIN_HIGH_ADDR |=> o_band_one_filter_type == $past(i_wdata[MODE_BIT]))
    else $error("band one type not written");
  chk_eq_applied: assert property (o_out_eq_applied == o_equaliser_enable)
    else $error("applied flag differs");
  chk_mix_stable: assert property (
    !(i_wr && i_addr == MIX_ENABLE_ADDR) |=> $stable(o_mixer_active))
    else $error("mixer status moved without write");
  chk_empty_ready: assert property (!o_out_valid |-> o_in_ready)
    else $error("empty buffer refuses");
endmodule : eqc_monitor

bind eqc_five_band_eq_control eqc_monitor i_mon (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .i_system_clock_budget, .i_system_clock_in_use, .i_other_fx_active,
  .o_in_ready, .o_out_valid, .o_out_eq_applied, .o_equaliser_enable, .o_band_one_filter_type,
  .o_band_one_gain_db, .o_gain_reserved, .o_mixer_active, .o_effects_path_status);

// >>> dv/eqc_sink.sv
// sample sink standing for the mixer inputs, prompt or randomly slow
module eqc_sink (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_stall,
  input wire logic i_slow,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  always @(posedge i_clk) begin
    if (i_rst || i_stall) o_ready <= 1'b0;
    else o_ready <= i_slow ? ($urandom_range(3) == 0) : 1'b1;
  end
endmodule : eqc_sink
